// ---- hdl/engine_defs.svh ----
// Shared constants of the conditional event engine.
// Assumes a single 200 MHz clock; times become cycle counts here.
//
// What this block does
// - Thirty-two conditionals, evaluated on events, not continuously.
// - Each holds a name, two variables, a function and a delay.
// - A true conditional emits up to four events, now or after delay.
// - Variable states are exported and reloadable to survive power loss.
// - Only events listed as a variable's set or clear start a table pass.
// - Matching events update variables; change or match retriggers users.
// - Blocked conditionals are never evaluated and never emit.
// - A true send-exit or exit conditional earlier in a group keeps later ones silent.
// - After a group member acts, the rest may be skipped.
// - Conditionals are evaluated in table order, first to last.
// - Mast groups emit only when the chosen aspect changes.
// - True without aspect change skips past group end, sending nothing.
// - True with aspect change starts delay, exits group, emits later.
// - A group with no true member emits nothing; scanning continues.
// - A null conditional last in a group fires as the default.
// - The last marker ends a group; skipping stops after it.
// - One consumed event sets each variable, another clears it.
// - Any conditional may be disabled by configuration.
// - True needs function and variables; null never triggers evaluation.
// - A variable may follow one of eight track circuit speeds.
// - Groups whose variables miss the event are passed over.
// - Each variable triggers on state change or on every match.
// - Sequential operator fires on second going true while first true.
// - Delay of 0 to 65535 ms, s or min; retrigger option.
// - Send-then-exit emits, then skips past the next group end.
`ifndef ENGINE_DEFS_SVH
`define ENGINE_DEFS_SVH
`define N_COND 32
`define EVID_W 64
`define TRK_W 3
`define DLY_W 16
`define CLK_NS 32'h5
`define MS_NS 32'hf4240
`define MS_CYC (`MS_NS / `CLK_NS)
`define S_MS 10'h3e8
`define MIN_S 6'h3c
`define IDX_LAST 5'h1f
`endif

// ---- hdl/engine_pkg.sv ----
// Types of the conditional event engine.
// Assumes engine_defs.svh is on the include path.
`default_nettype none
`include "engine_defs.svh"

package engine_pkg;
   typedef enum logic [1:0] {GRP_BLOCKED, GRP_MEMBER, GRP_LAST} grp_type;
   typedef enum logic [2:0] {F_AND, F_OR, F_XOR, F_AND_CHG, F_OR_CHG,
      F_SEQ_AND, F_NULL} func_type;
   typedef enum logic [1:0] {ACT_SEND_EXIT, ACT_SEND_NEXT, ACT_EXIT,
      ACT_NEXT} act_type;
   typedef enum logic [1:0] {U_MS, U_SEC, U_MIN} unit_type;
   typedef enum logic [1:0] {P_NONE, P_NOW, P_DELAY} pmode_type;
   typedef enum logic [1:0] {S_IDLE, S_UPD, S_SCAN} state_type;
   typedef struct packed {
      logic on_match;
      logic track;
      logic [`TRK_W-1:0] circ;
      logic [`TRK_W-1:0] speed;
      logic [`EVID_W-1:0] set_id;
      logic [`EVID_W-1:0] clr_id;
   } var_cfg_type;
   typedef struct packed {
      logic [`EVID_W-1:0] name;
      grp_type grp;
      func_type func;
      logic off;
      act_type act;
      logic [`DLY_W-1:0] delay;
      unit_type unit;
      logic retrig;
      var_cfg_type [1:0] v;
      pmode_type [3:0] pmode;
      logic [3:0][`EVID_W-1:0] prod;
   } cond_cfg_type;
   typedef struct packed {
      logic track;
      logic [`EVID_W-1:0] id;
      logic [`TRK_W-1:0] circ;
      logic [`TRK_W-1:0] speed;
   } bus_event_type;
endpackage
`default_nettype wire

// ---- hdl/var_match.sv ----
// Set and clear matcher of one variable.
// Assumes a registered event and static configuration.
`timescale 1ns/1ps
`default_nettype none

module var_match
   import engine_pkg::*;
(
   // Event under test
   input wire bus_event_type evt_i,
   // Variable configuration
   input wire var_cfg_type vcfg_i,
   // Hits
   output logic set_o,
   output logic clr_o
);

   wire logic circ_hit = vcfg_i.track & evt_i.track
      & (vcfg_i.circ == evt_i.circ);
   wire logic spd_eq = vcfg_i.speed == evt_i.speed;
   wire logic id_ok = !vcfg_i.track & !evt_i.track;

   // A speed report clears the other speeds of its circuit
   assign set_o = circ_hit ? spd_eq
      : id_ok & (evt_i.id == vcfg_i.set_id);
   assign clr_o = circ_hit ? !spd_eq
      : id_ok & (evt_i.id == vcfg_i.clr_id);

endmodule
`default_nettype wire

// ---- hdl/delay_timer.sv ----
// Action delay timer of one conditional.
// Assumes shared ms, s and min ticks from the engine.
`timescale 1ns/1ps
`default_nettype none
`include "engine_defs.svh"

module delay_timer
   import engine_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Control
   input wire logic start_i,
   input wire logic cancel_i,
   input wire logic retrig_i,
   input wire logic [`DLY_W-1:0] count_i,
   input wire unit_type unit_i,
   input wire logic [3:0] tick_i,
   // Expiry
   output logic done_o
);

   logic busy;
   logic [`DLY_W-1:0] left;

   wire logic tick = tick_i[unit_i];
   // Without retrigger a running delay ignores a new start
   wire logic load = start_i & (!busy | retrig_i);
   wire logic fin = busy & ((left == '0)
      | (tick & (left[`DLY_W-1:1] == '0)));

   always_ff @(posedge clk_i)
   begin
      if (!rst_b_i)
      begin
         busy <= 1'b0;
         left <= '0;
         done_o <= 1'b0;
      end
      else
      begin
         // Cancel wins so a false conditional kills its output
         done_o <= fin & !cancel_i & !load;
         if (cancel_i)
            busy <= 1'b0;
         else if (load)
         begin
            busy <= 1'b1;
            left <= count_i;
         end
         else if (fin)
            busy <= 1'b0;
         else if (tick)
            left <= left - 1'b1;
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   a_cancel_kills:
      assert property (cancel_i |=> !done_o)
      else $error("Timer fired after cancel");
   a_zero_fires:
      assert property (start_i && !busy && count_i == '0 && !cancel_i
         |=> (cancel_i || start_i) or (##1 done_o))
      else $error("Zero delay did not fire");

endmodule
`default_nettype wire

// ---- hdl/logic_engine.sv ----
// Conditional engine: 32 event-driven conditionals,
// one ordered pass through the table per listed consumed event.
// Assumes event, config and retained-image ports come from
// logic on REF_CLK_I, so none of them is synchronised.
`timescale 1ns/1ps
`default_nettype none
`include "engine_defs.svh"

module logic_engine
   import engine_pkg::*;
#(
   parameter int MS_CYC = `MS_CYC
)
(
   // Clock and reset
   input wire logic REF_CLK_I,
   input wire logic RST_B_I,
   // Conditional configuration
   input wire logic CFG_WE_I,
   input wire logic [4:0] CFG_IDX_I,
   input wire cond_cfg_type CFG_I,
   // Retained variable image
   input wire logic NV_LOAD_I,
   input wire logic [2*`N_COND-1:0] NV_DATA_I,
   output logic [2*`N_COND-1:0] NV_STATE_O,
   // Consumed events
   input wire logic EVT_VALID_I,
   input wire bus_event_type EVT_I,
   output logic EVT_READY_O,
   // Produced events
   output logic PROD_VALID_O,
   output logic [`EVID_W-1:0] PROD_ID_O,
   // Status
   output logic PASS_BUSY_O,
   output logic [`N_COND-1:0] ASPECT_O
);

   // ------------------------------------------------
   // Storage
   // ------------------------------------------------

   state_type st;
   state_type next_st;
   cond_cfg_type cfg [0:`N_COND-1];
   bus_event_type evt_q;
   logic [1:0] vq [0:`N_COND-1];
   logic [1:0] next_v [0:`N_COND-1];
   logic [`N_COND-1:0] trig_q;
   logic [`N_COND-1:0] next_trig;
   logic [`N_COND-1:0] lat;
   logic [`N_COND-1:0] ghit;
   logic acc;
   logic open_grp;
   logic [4:0] idx;
   logic skip;
   logic in_grp;
   logic [4*`N_COND-1:0] pend;
   logic [4*`N_COND-1:0] set_mask;
   logic [4*`N_COND-1:0] clr_mask;
   logic [`N_COND-1:0] send_v;
   logic [`N_COND-1:0] start_v;
   logic [`N_COND-1:0] cancel_v;
   logic [`N_COND-1:0] done_v;
   logic [2*`N_COND-1:0] hit_s;
   logic [2*`N_COND-1:0] hit_c;
   logic [31:0] ms_cnt;
   logic [9:0] s_cnt;
   logic [5:0] min_cnt;

   // ------------------------------------------------
   // Functions
   // ------------------------------------------------

   function automatic logic eval_func(input func_type f,
      input logic [1:0] v);
      logic r;
      r = 1'b0;
      case (f)
         F_AND, F_AND_CHG, F_SEQ_AND:
            r = v[0] & v[1];
         F_OR, F_OR_CHG:
            r = v[0] | v[1];
         F_XOR:
            r = v[0] ^ v[1];
         F_NULL:
            r = 1'b1;
         default:
            r = 1'b0;
      endcase
      return r;
   endfunction

   function automatic logic [6:0] low_idx(
      input logic [4*`N_COND-1:0] m);
      logic [6:0] r;
      r = 7'h0;
      for (int b = 4*`N_COND-1; b >= 0; b--)
      begin
         if (m[b])
            r = 7'(b);
      end
      return r;
   endfunction

   // ------------------------------------------------
   // Time base
   // ------------------------------------------------

   wire logic t_ms = ms_cnt == 32'(MS_CYC - 1);
   wire logic t_s = t_ms & (s_cnt == `S_MS - 10'h1);
   wire logic t_min = t_s & (min_cnt == `MIN_S - 6'h1);
   wire logic [3:0] ticks = {t_ms, t_min, t_s, t_ms};

   always_ff @(posedge REF_CLK_I)
   begin
      if (!RST_B_I)
      begin
         ms_cnt <= '0;
         s_cnt <= '0;
         min_cnt <= '0;
      end
      else
      begin
         ms_cnt <= t_ms ? '0 : ms_cnt + 32'h1;
         if (t_ms)
            s_cnt <= t_s ? '0 : s_cnt + 10'h1;
         if (t_s)
            min_cnt <= t_min ? '0 : min_cnt + 6'h1;
      end
   end

   // ------------------------------------------------
   // Per conditional: match, update, trigger, timer
   // ------------------------------------------------

   for (genvar c = 0; c < `N_COND; c++)
   begin : g_cond
      logic [1:0] chg;
      logic [1:0] mat;
      logic [1:0] trg;
      logic has_dly;

      for (genvar v = 0; v < 2; v++)
      begin : g_var
         var_match u_match (
            .evt_i (evt_q),
            .vcfg_i (cfg[c].v[v]),
            .set_o (hit_s[2*c+v]),
            .clr_o (hit_c[2*c+v])
         );
         // Trigger on state change or on any match
         assign trg[v] = cfg[c].v[v].on_match ? mat[v] : chg[v];
      end

      assign next_v[c] = hit_s[2*c+:2] | (vq[c] & ~hit_c[2*c+:2]);
      assign chg = next_v[c] ^ vq[c];
      assign mat = hit_s[2*c+:2] | hit_c[2*c+:2];
      // A null function never starts an evaluation
      assign next_trig[c] = (cfg[c].off | cfg[c].func == F_NULL) ? 1'b0
         : (cfg[c].func == F_SEQ_AND)
         ? chg[1] & next_v[c][1] & next_v[c][0]
         : |trg;

      assign has_dly = (cfg[c].pmode[0] == P_DELAY)
         | (cfg[c].pmode[1] == P_DELAY)
         | (cfg[c].pmode[2] == P_DELAY)
         | (cfg[c].pmode[3] == P_DELAY);
      assign start_v[c] = send_v[c] & has_dly;

      for (genvar k = 0; k < 4; k++)
      begin : g_act
         assign set_mask[4*c+k] =
            (send_v[c] & (cfg[c].pmode[k] == P_NOW))
            | (done_v[c] & (cfg[c].pmode[k] == P_DELAY));
      end

      delay_timer u_timer (
         .clk_i (REF_CLK_I),
         .rst_b_i (RST_B_I),
         .start_i (start_v[c]),
         .cancel_i (cancel_v[c]),
         .retrig_i (cfg[c].retrig),
         .count_i (cfg[c].delay),
         .unit_i (cfg[c].unit),
         .tick_i (ticks),
         .done_o (done_v[c])
      );
   end

   // ------------------------------------------------
   // Group reach: does any member of my group trigger
   // ------------------------------------------------

   always_comb
   begin
      acc = 1'b0;
      ghit = '0;
      open_grp = 1'b0;
      for (int j = `N_COND-1; j >= 0; j--)
      begin
         if (cfg[j].grp == GRP_LAST)
            acc = trig_q[j];
         else
            acc = acc | trig_q[j];
         ghit[j] = acc;
      end
      // Later members must see a trigger of an earlier one too
      for (int j = 1; j < `N_COND; j++)
      begin
         open_grp = (cfg[j-1].grp == GRP_MEMBER)
            | (open_grp & (cfg[j-1].grp == GRP_BLOCKED));
         if (open_grp)
            ghit[j] = ghit[j-1];
      end
   end

   // ------------------------------------------------
   // Scan decision for the entry at idx
   // ------------------------------------------------

   wire cond_cfg_type cur = cfg[idx];
   wire logic scan = st == S_SCAN;
   wire logic grouped = in_grp | (cur.grp == GRP_MEMBER);
   wire logic live = scan & ghit[idx] & !skip
      & (cur.grp != GRP_BLOCKED) & !cur.off;
   wire logic truth = eval_func(cur.func, vq[idx]);
   wire logic tru = live & truth;
   // Same aspect already shown: stay silent
   wire logic same = tru & grouped & lat[idx];
   wire logic sends = (cur.act == ACT_SEND_EXIT)
      | (cur.act == ACT_SEND_NEXT);
   wire logic send = tru & !same & sends;
   wire logic exit_grp = tru & (same
      | (cur.act == ACT_SEND_EXIT)
      | (cur.act == ACT_EXIT));
   // Losers of a reached group drop any delayed output
   wire logic kill = (live & !truth)
      | (scan & grouped & ghit[idx] & !tru);

   assign send_v = {{(`N_COND-1){1'b0}}, send} << idx;
   assign cancel_v = {{(`N_COND-1){1'b0}}, kill} << idx;

   // ------------------------------------------------
   // Output selection
   // ------------------------------------------------

   wire logic [6:0] sel = low_idx(pend);
   wire logic any_pend = |pend;
   wire cond_cfg_type sel_cfg = cfg[sel[6:2]];
   assign clr_mask = any_pend
      ? ({{(4*`N_COND-1){1'b0}}, 1'b1} << sel) : '0;

   // ------------------------------------------------
   // Sequencer
   // ------------------------------------------------

   always_comb
   begin
      next_st = st;
      case (st)
         S_IDLE:
            if (EVT_VALID_I && EVT_READY_O)
               next_st = S_UPD;
         S_UPD:
            // Unlisted events leave the table alone
            next_st = |{hit_s, hit_c} ? S_SCAN : S_IDLE;
         S_SCAN:
            if (idx == `IDX_LAST)
               next_st = S_IDLE;
         default:
            next_st = S_IDLE;
      endcase
   end

   always_ff @(posedge REF_CLK_I)
   begin
      if (!RST_B_I)
      begin
         st <= S_IDLE;
         EVT_READY_O <= 1'b0;
         PASS_BUSY_O <= 1'b0;
         evt_q <= '0;
      end
      else
      begin
         st <= next_st;
         EVT_READY_O <= next_st == S_IDLE;
         PASS_BUSY_O <= next_st != S_IDLE;
         if (st == S_IDLE && EVT_VALID_I && EVT_READY_O)
            evt_q <= EVT_I;
      end
   end

   // ------------------------------------------------
   // Configuration and variables
   // ------------------------------------------------

   always_ff @(posedge REF_CLK_I)
   begin
      for (int j = 0; j < `N_COND; j++)
      begin
         if (!RST_B_I)
            cfg[j] <= '0;
         else if (CFG_WE_I && CFG_IDX_I == 5'(j))
            cfg[j] <= CFG_I;
      end
   end

   // Image load only between passes, so a pass sees stable state
   always_ff @(posedge REF_CLK_I)
   begin
      for (int j = 0; j < `N_COND; j++)
      begin
         if (!RST_B_I)
            vq[j] <= '0;
         else if (st == S_IDLE && NV_LOAD_I)
            vq[j] <= NV_DATA_I[2*j+:2];
         else if (st == S_UPD)
            vq[j] <= next_v[j];
      end
   end

   always_ff @(posedge REF_CLK_I)
   begin
      for (int j = 0; j < `N_COND; j++)
      begin
         if (!RST_B_I)
            NV_STATE_O[2*j+:2] <= '0;
         else
            NV_STATE_O[2*j+:2] <= vq[j];
      end
   end

   always_ff @(posedge REF_CLK_I)
   begin
      if (!RST_B_I)
         trig_q <= '0;
      else if (st == S_UPD)
         trig_q <= next_trig;
   end

   // ------------------------------------------------
   // Pass state: order, skipping, aspects
   // ------------------------------------------------

   always_ff @(posedge REF_CLK_I)
   begin
      if (!RST_B_I)
      begin
         idx <= '0;
         skip <= 1'b0;
         in_grp <= 1'b0;
      end
      else if (st == S_UPD)
      begin
         idx <= '0;
         skip <= 1'b0;
         in_grp <= 1'b0;
      end
      else if (scan)
      begin
         idx <= idx + 5'h1;
         skip <= (cur.grp == GRP_LAST) ? 1'b0
            : skip | exit_grp;
         in_grp <= (cur.grp == GRP_MEMBER)
            | (in_grp & (cur.grp == GRP_BLOCKED));
      end
   end

   // The chosen member of a reached group holds the aspect
   always_ff @(posedge REF_CLK_I)
   begin
      if (!RST_B_I)
         lat <= '0;
      else if (scan && grouped && ghit[idx])
         lat[idx] <= tru;
   end

   always_ff @(posedge REF_CLK_I)
   begin
      if (!RST_B_I)
         ASPECT_O <= '0;
      else
         ASPECT_O <= lat;
   end

   // ------------------------------------------------
   // Produced events, one per cycle, lowest first
   // ------------------------------------------------

   always_ff @(posedge REF_CLK_I)
   begin
      if (!RST_B_I)
      begin
         pend <= '0;
         PROD_VALID_O <= 1'b0;
         PROD_ID_O <= '0;
      end
      else
      begin
         // New requests win over the clear of the same bit
         pend <= (pend & ~clr_mask) | set_mask;
         PROD_VALID_O <= any_pend;
         PROD_ID_O <= sel_cfg.prod[sel[1:0]];
      end
   end

   // ------------------------------------------------
   // Checks
   // ------------------------------------------------

   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_B_I);

   sequence s_pass_walk;
      scan && idx == 5'h0 ##31 scan && idx == `IDX_LAST;
   endsequence

   a_busy_refuse:
      assert property (PASS_BUSY_O |-> !EVT_READY_O)
      else $error("Ready raised during a pass");
   a_pass_walk:
      assert property (st == S_UPD && |{hit_s, hit_c}
         |=> s_pass_walk ##1 st == S_IDLE)
      else $error("Pass did not walk the table in order");
   a_unlisted_idle:
      assert property (st == S_UPD && !(|{hit_s, hit_c})
         |=> st == S_IDLE && EVT_READY_O)
      else $error("Unlisted event started a pass");
   a_blocked_quiet:
      assert property (scan && cur.grp == GRP_BLOCKED |-> !send && !tru)
      else $error("Blocked conditional acted");
   a_off_quiet:
      assert property (scan && cur.off |-> !send && !tru)
      else $error("Disabled conditional acted");
   a_same_skip:
      assert property (same && cur.grp == GRP_MEMBER |-> !send ##1 skip)
      else $error("Unchanged aspect was sent or not skipped");
   a_change_hold:
      assert property (send && grouped && cur.act == ACT_SEND_EXIT
         && cur.grp == GRP_MEMBER |=> skip && lat[$past(idx)])
      else $error("Aspect change did not latch and exit");
   a_null_silent:
      assert property (scan && cur.func == F_NULL |-> !trig_q[idx])
      else $error("Null function triggered a group");
   a_emit_next:
      assert property (any_pend |=> PROD_VALID_O)
      else $error("Pending event not produced");

endmodule
`default_nettype wire

// ---- tb/bus_node.sv ----
// Far-side node that offers consumed events to the engine.
// Assumes the engine takes an offer on an edge with ready high.
`timescale 1ns/1ps
`default_nettype none
`include "engine_defs.svh"

module bus_node
   import engine_pkg::*;
(
   // Clock
   input wire logic clk_i,
   // Event offer
   input wire logic ready_i,
   output logic valid_o,
   output bus_event_type evt_o
);
   initial
   begin
      valid_o = 1'b0;
      evt_o = '0;
   end

   // Offer held until taken or 300 cycles pass; released lines show junk, not the old id
   task automatic send(input logic [`EVID_W-1:0] id, output bit ok);
      int n;
      ok = 1'b0;
      @(posedge clk_i);
      valid_o <= 1'b1;
      evt_o <= '{track: 1'b0, id: id, circ: 3'h0, speed: 3'h0};
      for (n = 0; n < 300 && !ok; n++)
      begin
         @(posedge clk_i);
         ok = (ready_i === 1'b1);
      end
      valid_o <= 1'b0;
      evt_o <= ~evt_o;
   endtask
endmodule
`default_nettype wire

// ---- tb/event_logic_conditional_engine_tb.sv ----
// Self-checking bench of the conditional engine.
// Assumes the engine package and a short millisecond of 4 cycles.
`timescale 1ns/1ps
`default_nettype none
`include "engine_defs.svh"

module event_logic_conditional_engine_tb
   import engine_pkg::*;
;
   logic clk;
   logic rst_b;
   logic cfg_we;
   logic [4:0] cfg_idx;
   cond_cfg_type cfg;
   cond_cfg_type c;
   logic nv_load;
   logic [63:0] nv_data;
   logic [63:0] nv_state;
   logic evt_valid;
   logic evt_ready;
   bus_event_type evt;
   logic prod_valid;
   logic [63:0] prod_id;
   logic busy;
   logic [31:0] aspect;
   logic [63:0] exp_q[$];
   logic [63:0] p [8];
   logic [63:0] base;
   int num_errors = 0;
   int checks_done = 0;
   int unsigned seed;

   logic_engine #(.MS_CYC(4)) u_logic_engine (
      .REF_CLK_I(clk), .RST_B_I(rst_b),
      .CFG_WE_I(cfg_we), .CFG_IDX_I(cfg_idx), .CFG_I(cfg),
      .NV_LOAD_I(nv_load), .NV_DATA_I(nv_data), .NV_STATE_O(nv_state),
      .EVT_VALID_I(evt_valid), .EVT_I(evt), .EVT_READY_O(evt_ready),
      .PROD_VALID_O(prod_valid), .PROD_ID_O(prod_id),
      .PASS_BUSY_O(busy), .ASPECT_O(aspect)
   );

   bus_node u_bus_node (
      .clk_i(clk), .ready_i(evt_ready), .valid_o(evt_valid), .evt_o(evt)
   );

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic conclude();
      if (num_errors == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic check(input logic [63:0] seen, input logic [63:0] want,
      input string what);
      checks_done++;
      if (seen !== want)
      begin
         num_errors++;
         $display("MISMATCH %0t %s", $time, what);
      end
   endtask

   // Oldest note is matched against each produced event
   always @(posedge clk)
   begin
      if (prod_valid === 1'b1)
      begin
         if (exp_q.size() == 0)
            check(64'h1, 64'h0, "unexpected event");
         else
            check(prod_id, exp_q.pop_front(), "event id");
      end
   end

   task automatic put(input logic [4:0] idx);
      @(posedge clk);
      cfg_idx <= idx;
      cfg <= c;
      cfg_we <= 1'b1;
      @(posedge clk);
      cfg_we <= 1'b0;
   endtask

   // Waits for the pass and every noted event, then a quiet spell
   task automatic ev(input logic [2:0] k);
      bit ok;
      int n;
      u_bus_node.send(base | 64'(k), ok);
      if (!ok)
         check(64'h1, 64'h0, "event not taken");
      repeat (2) @(posedge clk);
      check(64'({busy, evt_ready}), 64'h2, "pass busy");
      for (n = 0; n < 600; n++)
      begin
         if (exp_q.size() == 0 && evt_ready === 1'b1)
            break;
         @(posedge clk);
      end
      if (n == 600)
      begin
         num_errors++;
         conclude();
      end
      repeat (40) @(posedge clk);
   endtask

   // ----------------------------------------
   // Stimulus
   // ----------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial
   begin
      rst_b = 1'b0;
      cfg_we = 1'b0;
      cfg_idx = 5'h0;
      cfg = '0;
      nv_load = 1'b0;
      nv_data = '0;
      seed = $urandom(56);
      base = {$urandom(), 32'h0};
      foreach (p[i])
         p[i] = {$urandom(), $urandom()};
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      // Single conditional, two immediate actions
      c = '0;
      c.grp = GRP_LAST;
      c.func = F_OR;
      c.act = ACT_SEND_NEXT;
      c.v[0].set_id = base | 64'h1;
      c.v[0].clr_id = base | 64'h2;
      c.pmode[0] = P_NOW;
      c.pmode[1] = P_NOW;
      c.prod[0] = p[0];
      c.prod[1] = p[1];
      put(5'h0);
      // Mast group: one member, then a null default
      c.grp = GRP_MEMBER;
      c.act = ACT_SEND_EXIT;
      c.pmode[1] = P_NONE;
      c.v[0].on_match = 1'b1;
      c.v[0].set_id = base | 64'h3;
      c.v[0].clr_id = base | 64'h4;
      c.prod[0] = p[2];
      put(5'h1);
      c.grp = GRP_LAST;
      c.func = F_NULL;
      c.prod[0] = p[3];
      put(5'h2);
      // Same trigger: delayed one, disabled one, blocked one
      c.func = F_OR;
      c.v[0].on_match = 1'b0;
      c.v[0].set_id = base | 64'h5;
      c.v[0].clr_id = base | 64'h6;
      c.delay = 16'h2;
      c.unit = U_MS;
      c.pmode[0] = P_DELAY;
      c.prod[0] = p[4];
      put(5'h3);
      c.pmode[0] = P_NOW;
      c.off = 1'b1;
      c.prod[0] = p[5];
      put(5'h4);
      c.off = 1'b0;
      c.grp = GRP_BLOCKED;
      c.prod[0] = p[6];
      put(5'h5);
      // Sequential operator on its own
      c.grp = GRP_LAST;
      c.func = F_SEQ_AND;
      c.v[0].set_id = base | 64'h7;
      c.v[0].clr_id = base;
      c.v[1].set_id = base | 64'h1;
      c.v[1].clr_id = base | 64'h2;
      c.prod[0] = p[7];
      put(5'h6);

      exp_q.push_back(p[0]);
      exp_q.push_back(p[1]);
      ev(3'h1);
      check(64'(nv_state[1:0]), 64'h1, "set variable");
      ev(3'h1);
      ev(3'h2);
      check(64'(nv_state[1:0]), 64'h0, "clear variable");
      exp_q.push_back(p[2]);
      ev(3'h3);
      check(64'(aspect[2:1]), 64'h1, "aspect member");
      ev(3'h3);
      exp_q.push_back(p[3]);
      ev(3'h4);
      check(64'(aspect[2:1]), 64'h2, "aspect default");
      exp_q.push_back(p[4]);
      ev(3'h5);
      ev(3'h7);
      exp_q.push_back(p[0]);
      exp_q.push_back(p[1]);
      exp_q.push_back(p[7]);
      ev(3'h1);
      // Retained image reload while idle
      @(posedge clk);
      nv_data <= {$urandom(), $urandom()};
      nv_load <= 1'b1;
      @(posedge clk);
      nv_load <= 1'b0;
      repeat (2) @(posedge clk);
      check(nv_state, nv_data, "image reload");
      conclude();
   end
endmodule
`default_nettype wire
